// [rxcfg_pkg.sv]
// What this block does
// - Rate select latch resets to 1 in every channel.
// - Rate 1, source 0: complementary clock from recovered clock, half rate.
// - Rate 0, source 0: complementary clock from recovered clock, full rate.
// - Rate 1, source 1, full-rate reference: clock follows reference, half rate.
// - Rate 0, source 1, full-rate reference: clock follows reference, full rate.
// - Source 1 with half-rate reference ignores rate; output half rate.
// - Two-bit primary detector threshold per channel, resets to binary 10.
// - Primary threshold 00 disables the primary analog detector.
// - Primary values 01, 10, 11 select 140, 280, 420 mV.
// - Two-bit secondary detector threshold per channel, resets to binary 10.
// - Secondary 00 disables detector; other codes match primary levels.
// - Encoder enable latch resets to 1; 1 keeps encoder active.
// - Encoder enable 0 sends raw 10-bit characters unencoded.
// - Source select resets to 1; 1 uses reference, 0 recovered clock.
package rxcfg_pkg;
   localparam int          RXCFG_NCH           = 4;
   localparam logic [11:0] RXCFG_CFG_OFFSET0   = 12'h000;
   localparam logic [11:0] RXCFG_STATUS_OFFSET = 12'h010;
   localparam logic [11:0] RXCFG_INFO_OFFSET   = 12'h014;
   localparam int          RXCFG_RATE_BIT      = 0;
   localparam int          RXCFG_SRC_BIT       = 1;
   localparam int          RXCFG_PRI_LSB       = 2;
   localparam int          RXCFG_SEC_LSB       = 4;
   localparam int          RXCFG_ENC_BIT       = 6;
   localparam int          RXCFG_REFHALF_BIT   = 7;
   localparam logic        RXCFG_RATE_RST      = 1'b1;
   localparam logic        RXCFG_SRC_RST       = 1'b1;
   localparam logic [1:0]  RXCFG_THR_RST       = 2'h2;
   localparam logic        RXCFG_ENC_RST       = 1'b1;
   localparam logic        RXCFG_REFHALF_RST   = 1'b0;
   localparam logic [1:0]  RXCFG_THR_OFF       = 2'h0;
   localparam logic [9:0]  RXCFG_MV_140        = 10'h08c;
   localparam logic [9:0]  RXCFG_MV_280        = 10'h118;
   localparam logic [9:0]  RXCFG_MV_420        = 10'h1a4;
   localparam logic [1:0]  RXCFG_RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RXCFG_RESP_SLVERR   = 2'h2;

   typedef struct packed {
      logic       ref_half;
      logic       enc_enable;
      logic [1:0] sec_thr;
      logic [1:0] pri_thr;
      logic       src_sel;
      logic       rate_sel;
   } rxcfg_chan_t;

   typedef struct packed {
      logic       pri_det_en;
      logic [9:0] pri_mv;
      logic       sec_det_en;
      logic [9:0] sec_mv;
   } rxcfg_det_t;

   typedef enum logic [2:0] {
      RXCFG_CLK_FULL_REC = 3'b001,
      RXCFG_CLK_HALF     = 3'b010,
      RXCFG_CLK_FULL_REF = 3'b100
   } rxcfg_clkmode_t;
endpackage

// [rxcfg_clkgen.sv]
`timescale 1ns/1ps
// One channel's receive clock generator. The selected source is sampled as an
// ordinary input; the output toggles on each source rising edge for half rate
// and follows the source level for full rate.
module rxcfg_clkgen
   import rxcfg_pkg::*;
(
   input  wire logic           aclk,
   input  wire logic           aresetn,
   input  wire rxcfg_chan_t    cfg,
   input  wire logic           recovered_clock,
   input  wire logic           reference_clock_in,
   output logic                rx_clock_output_p,
   output logic                rx_clock_output_n,
   output rxcfg_clkmode_t      mode
);
   logic src_now;
   logic src_prev_q;
   logic out_q;

   always_comb
   begin
      if (cfg.src_sel)
         src_now = reference_clock_in;
      else
         src_now = recovered_clock;
   end

   always_comb
   begin
      if (cfg.src_sel && cfg.ref_half)
         mode = RXCFG_CLK_HALF;
      else if (cfg.rate_sel)
         mode = RXCFG_CLK_HALF;
      else if (cfg.src_sel)
         mode = RXCFG_CLK_FULL_REF;
      else
         mode = RXCFG_CLK_FULL_REC;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         src_prev_q <= 1'b0;
      else
         src_prev_q <= src_now;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         out_q <= 1'b0;
      else
      begin
         case (mode)
            // Toggling from the output's own value keeps a mode change from
            // swallowing the first half-rate edge.
            RXCFG_CLK_HALF:     out_q <= (src_now && !src_prev_q) ? ~out_q : out_q;
            RXCFG_CLK_FULL_REC: out_q <= src_now;
            RXCFG_CLK_FULL_REF: out_q <= src_now;
            default:            out_q <= 1'b0;
         endcase
      end
   end

   // Complement is built from the same flop so the pair never skews apart.
   assign rx_clock_output_p = out_q;
   assign rx_clock_output_n = ~out_q;

   AST_HALF_TOGGLES: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode == RXCFG_CLK_HALF && src_now && !src_prev_q)
      |=> (out_q != $past(out_q)))
      else $error("half rate output did not toggle on source edge");
   AST_FULL_FOLLOWS: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode == RXCFG_CLK_FULL_REC) |=> (out_q == $past(src_now)))
      else $error("full rate output does not follow source");
   AST_REFHALF_IGNORES_RATE: assert property (@(posedge aclk) disable iff (!aresetn)
      (cfg.src_sel && cfg.ref_half) |-> (mode == RXCFG_CLK_HALF))
      else $error("half rate reference did not force half rate");
endmodule // rxcfg_clkgen

// [rxcfg_top.sv]
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
// Per-channel configuration latches behind an AXI4-Lite slave. Channel n's
// latches sit at byte offset 4*n; a status word reports the resolved clock
// mode and detector enables.
module rxcfg_top
   import rxcfg_pkg::*;
#(
   parameter int NCH = RXCFG_NCH
)
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [11:0]       s_axil_awaddr,
   input  wire logic              s_axil_awvalid,
   output logic                   s_axil_awready,
   input  wire logic [31:0]       s_axil_wdata,
   input  wire logic [3:0]        s_axil_wstrb,
   input  wire logic              s_axil_wvalid,
   output logic                   s_axil_wready,
   output logic [1:0]             s_axil_bresp,
   output logic                   s_axil_bvalid,
   input  wire logic              s_axil_bready,
   input  wire logic [11:0]       s_axil_araddr,
   input  wire logic              s_axil_arvalid,
   output logic                   s_axil_arready,
   output logic [31:0]            s_axil_rdata,
   output logic [1:0]             s_axil_rresp,
   output logic                   s_axil_rvalid,
   input  wire logic              s_axil_rready,
   input  wire logic [NCH-1:0]    recovered_clock,
   input  wire logic [NCH-1:0]    reference_clock_in,
   output logic [NCH-1:0]         rx_clock_output_p,
   output logic [NCH-1:0]         rx_clock_output_n,
   output rxcfg_det_t [NCH-1:0]   detect_cfg,
   output logic [NCH-1:0]         transmit_encoder_enable,
   output logic [NCH-1:0]         encoder_bypass_raw10
);
   rxcfg_chan_t    cfg_q [NCH];
   rxcfg_clkmode_t mode [NCH];
   rxcfg_det_t     det_q [NCH];

   logic        aw_held_q;
   logic [11:0] awaddr_q;
   logic        w_held_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        do_write;
   logic        wr_hit;
   logic [31:0] rd_word;
   logic        rd_hit;

   // Returns the channel index for a channel window address, or NCH if none.
   function automatic int chan_of(input logic [11:0] addr);
      int idx;
      idx = NCH;
      for (int i = 0; i < NCH; i++)
      begin
         if (addr == RXCFG_CFG_OFFSET0 + 12'(4 * i))
            idx = i;
      end
      return idx;
   endfunction

   function automatic logic [9:0] thr_mv(input logic [1:0] code);
      logic [9:0] mv;
      mv = 10'h000;
      case (code)
         2'h1:    mv = RXCFG_MV_140;
         2'h2:    mv = RXCFG_MV_280;
         2'h3:    mv = RXCFG_MV_420;
         default: mv = 10'h000;
      endcase
      return mv;
   endfunction

   // Address and data are held independently so either may arrive first.
   assign s_axil_awready = !aw_held_q && !s_axil_bvalid;
   assign s_axil_wready  = !w_held_q && !s_axil_bvalid;
   assign do_write       = aw_held_q && w_held_q && !s_axil_bvalid;
   assign wr_hit         = chan_of(awaddr_q) < NCH;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_q <= 1'b0;
         awaddr_q  <= 12'h000;
      end
      else if (s_axil_awvalid && s_axil_awready)
      begin
         aw_held_q <= 1'b1;
         awaddr_q  <= s_axil_awaddr;
      end
      else if (do_write)
         aw_held_q <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_q <= 1'b0;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
      end
      else if (s_axil_wvalid && s_axil_wready)
      begin
         w_held_q <= 1'b1;
         wdata_q  <= s_axil_wdata;
         wstrb_q  <= s_axil_wstrb;
      end
      else if (do_write)
         w_held_q <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axil_bvalid <= 1'b0;
         s_axil_bresp  <= RXCFG_RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axil_bvalid <= 1'b1;
         s_axil_bresp  <= wr_hit ? RXCFG_RESP_OKAY : RXCFG_RESP_SLVERR;
      end
      else if (s_axil_bready)
         s_axil_bvalid <= 1'b0;
   end

   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : g_chan
         // Only byte lane 0 carries fields; other lanes are ignored.
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               cfg_q[g].rate_sel   <= RXCFG_RATE_RST;
               cfg_q[g].src_sel    <= RXCFG_SRC_RST;
               cfg_q[g].pri_thr    <= RXCFG_THR_RST;
               cfg_q[g].sec_thr    <= RXCFG_THR_RST;
               cfg_q[g].enc_enable <= RXCFG_ENC_RST;
               cfg_q[g].ref_half   <= RXCFG_REFHALF_RST;
            end
            else if (do_write && wstrb_q[0] && chan_of(awaddr_q) == g)
            begin
               cfg_q[g].rate_sel   <= wdata_q[RXCFG_RATE_BIT];
               cfg_q[g].src_sel    <= wdata_q[RXCFG_SRC_BIT];
               cfg_q[g].pri_thr    <= wdata_q[RXCFG_PRI_LSB +: 2];
               cfg_q[g].sec_thr    <= wdata_q[RXCFG_SEC_LSB +: 2];
               cfg_q[g].enc_enable <= wdata_q[RXCFG_ENC_BIT];
               cfg_q[g].ref_half   <= wdata_q[RXCFG_REFHALF_BIT];
            end
         end

         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               det_q[g] <= '0;
            else
            begin
               det_q[g].pri_det_en <= cfg_q[g].pri_thr != RXCFG_THR_OFF;
               det_q[g].pri_mv     <= thr_mv(cfg_q[g].pri_thr);
               det_q[g].sec_det_en <= cfg_q[g].sec_thr != RXCFG_THR_OFF;
               det_q[g].sec_mv     <= thr_mv(cfg_q[g].sec_thr);
            end
         end

         assign detect_cfg[g]              = det_q[g];
         assign transmit_encoder_enable[g] = cfg_q[g].enc_enable;
         assign encoder_bypass_raw10[g]    = !cfg_q[g].enc_enable;

         rxcfg_clkgen u_clkgen (
            .aclk               (aclk),
            .aresetn            (aresetn),
            .cfg                (cfg_q[g]),
            .recovered_clock    (recovered_clock[g]),
            .reference_clock_in (reference_clock_in[g]),
            .rx_clock_output_p  (rx_clock_output_p[g]),
            .rx_clock_output_n  (rx_clock_output_n[g]),
            .mode               (mode[g])
         );

         AST_DET_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
            (cfg_q[g].pri_thr == RXCFG_THR_OFF) |=> !det_q[g].pri_det_en)
            else $error("primary detector not disabled by code 00");
         AST_DET_MV: assert property (@(posedge aclk) disable iff (!aresetn)
            (cfg_q[g].pri_thr == 2'h3) |=> (det_q[g].pri_mv == RXCFG_MV_420))
            else $error("primary threshold 11 not 420 mV");
         AST_SEC_MV: assert property (@(posedge aclk) disable iff (!aresetn)
            (cfg_q[g].sec_thr == 2'h1) |=> (det_q[g].sec_mv == RXCFG_MV_140))
            else $error("secondary threshold 01 not 140 mV");
         AST_RESET_VALUES: assert property (@(posedge aclk)
            !aresetn |=> (cfg_q[g].rate_sel && cfg_q[g].src_sel
                          && cfg_q[g].pri_thr == 2'h2 && cfg_q[g].sec_thr == 2'h2
                          && cfg_q[g].enc_enable))
            else $error("latch reset values wrong");
         AST_ENC_RAW: assert property (@(posedge aclk) disable iff (!aresetn)
            encoder_bypass_raw10[g] != transmit_encoder_enable[g])
            else $error("encoder bypass and enable disagree");
         AST_OTHER_CHAN: assert property (@(posedge aclk) disable iff (!aresetn)
            (do_write && chan_of(awaddr_q) != g) |=> $stable(cfg_q[g]))
            else $error("write disturbed another channel");
      end
   endgenerate

   always_comb
   begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      if (chan_of(s_axil_araddr) < NCH)
         rd_word = {24'h000000, cfg_q[chan_of(s_axil_araddr)]};
      else if (s_axil_araddr == RXCFG_STATUS_OFFSET)
      begin
         for (int i = 0; i < NCH; i++)
         begin
            rd_word[i*5 +: 3] = mode[i];
            rd_word[i*5 + 3]  = det_q[i].pri_det_en;
            rd_word[i*5 + 4]  = det_q[i].sec_det_en;
         end
      end
      else if (s_axil_araddr == RXCFG_INFO_OFFSET)
         rd_word = 32'(NCH);
      else
         rd_hit = 1'b0;
   end

   assign s_axil_arready = !s_axil_rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axil_rvalid <= 1'b0;
         s_axil_rdata  <= 32'h0000_0000;
         s_axil_rresp  <= RXCFG_RESP_OKAY;
      end
      else if (s_axil_arvalid && s_axil_arready)
      begin
         s_axil_rvalid <= 1'b1;
         s_axil_rdata  <= rd_word;
         s_axil_rresp  <= rd_hit ? RXCFG_RESP_OKAY : RXCFG_RESP_SLVERR;
      end
      else if (s_axil_rready)
         s_axil_rvalid <= 1'b0;
   end

   AST_WRITE_RESP: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write |=> s_axil_bvalid)
      else $error("write response missing");
endmodule // rxcfg_top

// [rxcfg_host.sv]
`timescale 1ns/1ps
// Host-side model. Recovered and reference clocks run at different periods so
// that a wrong source choice shows up in the capture counts.
module rxcfg_host
   import rxcfg_pkg::*;
#(
   parameter int REC_HALF = 3,
   parameter int REF_HALF = 5
)
(
   input  wire logic        aclk,
   input  wire logic        clear,
   input  wire logic [3:0]  rx_clock_output_p,
   input  wire logic [3:0]  rx_clock_output_n,
   output logic [3:0]       recovered_clock,
   output logic [3:0]       reference_clock_in,
   output logic [15:0]      rec_rises,
   output logic [15:0]      ref_rises,
   output logic [3:0][15:0] cap_p,
   output logic [3:0][15:0] cap_n
);
   int         tick = 0;
   logic [3:0] p_q = '0;
   logic [3:0] n_q = '1;
   initial
   begin
      recovered_clock = '0;
      reference_clock_in = '0;
   end
   always @(posedge aclk)
   begin
      tick <= tick + 1;
      if (tick % REC_HALF == 0)
         recovered_clock <= ~recovered_clock;
      if (tick % REF_HALF == 0)
         reference_clock_in <= ~reference_clock_in;
      p_q <= rx_clock_output_p;
      n_q <= rx_clock_output_n;
      if (clear)
      begin
         rec_rises <= '0;
         ref_rises <= '0;
         cap_p <= '0;
         cap_n <= '0;
      end
      else
      begin
         rec_rises <= rec_rises + 16'(tick % REC_HALF == 0 && !recovered_clock[0]);
         ref_rises <= ref_rises + 16'(tick % REF_HALF == 0 && !reference_clock_in[0]);
         for (int c = 0; c < 4; c++)
         begin
            cap_p[c] <= cap_p[c] + 16'(rx_clock_output_p[c] & !p_q[c]);
            cap_n[c] <= cap_n[c] + 16'(rx_clock_output_n[c] & !n_q[c]);
         end
      end
   end
endmodule // rxcfg_host

// [rx_clock_rate_detect_encoder_config_tb.sv]
`timescale 1ns/1ps
module rx_clock_rate_detect_encoder_config_tb;
   import rxcfg_pkg::*;
   logic             aclk, aresetn, s_axil_awvalid, s_axil_awready, s_axil_wvalid;
   logic             s_axil_wready, s_axil_bvalid, s_axil_bready, s_axil_arvalid;
   logic             s_axil_arready, s_axil_rvalid, s_axil_rready, clr;
   logic [11:0]      s_axil_awaddr, s_axil_araddr;
   logic [31:0]      s_axil_wdata, s_axil_rdata, seed;
   logic [3:0]       s_axil_wstrb, recovered_clock, reference_clock_in;
   logic [3:0]       rx_clock_output_p, rx_clock_output_n;
   logic [3:0]       transmit_encoder_enable, encoder_bypass_raw10;
   logic [1:0]       s_axil_bresp, s_axil_rresp, ch;
   logic [15:0]      rec_rises, ref_rises, src_n, got;
   logic [3:0][15:0] cap_p, cap_n;
   rxcfg_det_t [3:0] detect_cfg;
   logic [7:0]       cfg_m [4];
   logic [1:0]       wq [$];
   logic [33:0]      rq [$];
   logic [33:0]      e;
   logic [2:0]       modes [6] = '{3'b001, 3'b000, 3'b011, 3'b010, 3'b110, 3'b111};
   int               n_fail = 0, check_count = 0, cyc = 0;
   rxcfg_top dut (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready,
      .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp,
      .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready,
      .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .recovered_clock,
      .reference_clock_in, .rx_clock_output_p, .rx_clock_output_n, .detect_cfg,
      .transmit_encoder_enable, .encoder_bypass_raw10);
   rxcfg_host host (.aclk, .clear(clr), .rx_clock_output_p, .rx_clock_output_n,
      .recovered_clock, .reference_clock_in, .rec_rises, .ref_rises, .cap_p, .cap_n);
   always #5 aclk = ~aclk;
   task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
      check_count++;
      if (g !== x)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, x);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic logic [9:0] mv(input logic [1:0] t);
      return t == 2'h0 ? 10'h0 : t == 2'h1 ? RXCFG_MV_140 : t == 2'h2 ? RXCFG_MV_280 : RXCFG_MV_420;
   endfunction
   function automatic logic [31:0] stat();
      logic [31:0] v;
      v = '0;
      for (int n = 0; n < 4; n++)
      begin
         v[5*n +: 3] = (cfg_m[n][0] | (cfg_m[n][1] & cfg_m[n][7])) ? RXCFG_CLK_HALF :
            cfg_m[n][1] ? RXCFG_CLK_FULL_REF : RXCFG_CLK_FULL_REC;
         v[5*n+3] = |cfg_m[n][3:2];
         v[5*n+4] = |cfg_m[n][5:4];
      end
      return v;
   endfunction
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      wq.push_back(a < 12'h010 ? RXCFG_RESP_OKAY : RXCFG_RESP_SLVERR);
      if (a < 12'h010 && s[0])
         cfg_m[a[3:2]] = d[7:0];
      @(posedge aclk);
      s_axil_awaddr <= a;
      s_axil_wdata <= d;
      s_axil_wstrb <= s;
      s_axil_awvalid <= 1'b1;
      s_axil_wvalid <= 1'b1;
      s_axil_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axil_awvalid && s_axil_awready)
            s_axil_awvalid <= 1'b0;
         if (s_axil_wvalid && s_axil_wready)
            s_axil_wvalid <= 1'b0;
      end while (!s_axil_bvalid);
      s_axil_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      logic [1:0]  r;
      logic [31:0] d;
      r = RXCFG_RESP_OKAY;
      d = '0;
      if (a < 12'h010)
         d = {24'h0, cfg_m[a[3:2]]};
      else if (a == RXCFG_STATUS_OFFSET)
         d = stat();
      else if (a == RXCFG_INFO_OFFSET)
         d = RXCFG_NCH;
      else
         r = RXCFG_RESP_SLVERR;
      rq.push_back({r, d});
      @(posedge aclk);
      s_axil_araddr <= a;
      s_axil_arvalid <= 1'b1;
      s_axil_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axil_arvalid && s_axil_arready)
            s_axil_arvalid <= 1'b0;
      end while (!s_axil_rvalid);
      s_axil_rready <= 1'b0;
   endtask
   task automatic outs();
      repeat (2) @(posedge aclk);
      #1;
      for (int n = 0; n < 4; n++)
         chk({8'h0, detect_cfg[n], transmit_encoder_enable[n], encoder_bypass_raw10[n]},
            {8'h0, |cfg_m[n][3:2], mv(cfg_m[n][3:2]), |cfg_m[n][5:4], mv(cfg_m[n][5:4]),
            cfg_m[n][6], !cfg_m[n][6]}, "port config");
   endtask
   always @(posedge aclk)
   begin
      if (s_axil_bvalid && s_axil_bready)
         chk({30'h0, s_axil_bresp}, {30'h0, wq.pop_front()}, "write response");
      if (s_axil_rvalid && s_axil_rready)
      begin
         e = rq.pop_front();
         chk({30'h0, s_axil_rresp}, {30'h0, e[33:32]}, "read response");
         if (e[33:32] == RXCFG_RESP_OKAY)
            chk(s_axil_rdata, e[31:0], "read data");
      end
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         end_of_test();
      end
   end
   initial
   begin
      {aclk, aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready, clr} = '0;
      {s_axil_arvalid, s_axil_rready, s_axil_awaddr, s_axil_araddr} = '0;
      s_axil_wdata = '0;
      s_axil_wstrb = '0;
      seed = 32'hc82b;
      for (int n = 0; n < 4; n++)
         cfg_m[n] = 8'h6b;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      for (int n = 0; n < 4; n++)
         rd(12'(4 * n));
      rd(RXCFG_STATUS_OFFSET);
      rd(RXCFG_INFO_OFFSET);
      rd(12'h020);
      outs();
      for (int t = 0; t < 4; t++)
      begin
         ch = 2'($random(seed));
         wr({8'h0, ch, 2'b00}, {25'h0, t[0], 2'(3 - t), 2'(t), 2'b11}, 4'hf);
         outs();
      end
      wr(12'h000, 32'h0, 4'he);
      wr(RXCFG_STATUS_OFFSET, 32'hff, 4'hf);
      rd(12'h000);
      rd(RXCFG_STATUS_OFFSET);
      for (int k = 0; k < 6; k++)
      begin
         ch = 2'($random(seed));
         wr({8'h0, ch, 2'b00}, {24'h0, modes[k][2], 5'b11010, modes[k][1:0]}, 4'h1);
         rd(RXCFG_STATUS_OFFSET);
         clr <= 1'b1;
         @(posedge aclk);
         clr <= 1'b0;
         repeat (200) @(posedge aclk);
         #1;
         src_n = modes[k][1] ? ref_rises : rec_rises;
         got = (modes[k][0] | (modes[k][1] & modes[k][2])) ? cap_p[ch] + cap_n[ch] : cap_p[ch];
         chk(32'(got + 2 >= src_n && got <= src_n + 2), 1, "clock rate");
         chk({28'h0, rx_clock_output_n}, {28'h0, ~rx_clock_output_p}, "complement");
      end
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      for (int n = 0; n < 4; n++)
         cfg_m[n] = 8'h6b;
      rd(12'h00c);
      outs();
      end_of_test();
   end
endmodule // rx_clock_rate_detect_encoder_config_tb
